// [rtl/tpc_pkg.sv]
/*
  Shared constants of the push-button tap counter: wiper position
  layout, reset values, scan and debounce timing, control states.
  Assumes a single 100 MHz core clock feeding every module.
*/
package tpc_pkg;

  // ****************************************
  // Wiper position layout
  // ****************************************
  localparam int POS_W = 5;
  localparam int TAP_N = 32;
  localparam logic [4:0] POS_MIN = 5'h00;
  localparam logic [4:0] POS_MAX = 5'h1F;
  localparam logic [4:0] POS_RESET = 5'h00;
  localparam logic [31:0] TAP_RESET = 32'h0000_0001;

  // ****************************************
  // Timing, in printed units and in cycles
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS = 1000000;
  localparam int DEBOUNCE_MS = 40;
  localparam int SLOW_SCAN_MS = 250;
  localparam int FAST_SCAN_MS = 50;
  localparam int FAST_AFTER_MS = 1000;
  localparam int DEBOUNCE_CYC = (DEBOUNCE_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_SCAN_CYC = (SLOW_SCAN_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int FAST_SCAN_CYC = (FAST_SCAN_MS * NS_PER_MS) / CLK_PERIOD_NS;
  localparam int FAST_AFTER_CYC = (FAST_AFTER_MS * NS_PER_MS) / CLK_PERIOD_NS;
  // Extra settle cycles covering the input synchronisers
  localparam int SETTLE_EXTRA_CYC = 4;
  localparam int TMR_W = 27;

  // ****************************************
  // Control states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RECALL = 3'b000,
    ST_SETTLE = 3'b001,
    ST_IDLE = 3'b010,
    ST_SLOW = 3'b011,
    ST_FAST = 3'b100
  } tpc_state_type;

endpackage

// [rtl/tpc_debounce.sv]
/*
  Two-flop synchroniser and debounce filter for one active-low pin.
  Assumes the pin is asynchronous to core_clk and idles high.
*/
`timescale 1ns/1ns
`default_nettype none

module tpc_debounce
  import tpc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int CW = TMR_W,
  parameter bit FILTER_RELEASE = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Raw pin and filtered level
  input wire logic pin_n,
  output logic level_n
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (DEB_CYC < 2 || DEB_CYC >= (2 ** CW)) begin : g_chk
    $error("tpc_debounce: DEB_CYC out of range");
  end

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic filt;
    logic [CW-1:0] cnt;
    logic [CW-1:0] low_run;
  } tpc_deb_type;

  tpc_deb_type q_ff;
  tpc_deb_type nxt_q;

  // Filter: a new level must stand for DEB_CYC samples
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sync1 = pin_n;
    nxt_q.sync2 = q_ff.sync1;
    if (q_ff.sync2 == q_ff.filt) begin
      nxt_q.cnt = '0;
    end else if (q_ff.cnt == CW'(DEB_CYC - 1)) begin
      nxt_q.filt = q_ff.sync2;
      nxt_q.cnt = '0;
    end else begin
      nxt_q.cnt = q_ff.cnt + 1'b1;
    end
    // Release passes at once where not filtered
    if (!FILTER_RELEASE && q_ff.sync2 && !q_ff.filt) begin
      nxt_q.filt = 1'b1;
      nxt_q.cnt = '0;
    end
    // Length of the current low run, for checking
    if (q_ff.sync2) begin
      nxt_q.low_run = '0;
    end else if (q_ff.low_run != CW'(DEB_CYC)) begin
      nxt_q.low_run = q_ff.low_run + 1'b1;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '{sync1: 1'b1, sync2: 1'b1, filt: 1'b1, cnt: '0, low_run: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign level_n = q_ff.filt;

  // ****************************************
  // Checks
  // ****************************************
  short_low_a: assert property (@(posedge core_clk) disable iff (reset)
    $fell(q_ff.filt) |-> q_ff.low_run == CW'(DEB_CYC))
    else $error("press accepted before debounce interval");

endmodule

`default_nettype wire

// [rtl/tpc_tap_decode.sv]
/*
  Decodes the wiper count into a one-hot tap switch selection.
  Assumes the count comes from logic on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module tpc_tap_decode
  import tpc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Count in, switch selection out
  input wire logic [4:0] pos,
  output logic [31:0] tap_sel
);

  typedef struct packed {
    logic [31:0] sel;
  } tpc_dec_type;

  tpc_dec_type q_ff;
  tpc_dec_type nxt_q;
  logic [31:0] dec;

  // One compare per tap switch
  for (genvar g = 0; g < TAP_N; g++) begin : g_tap
    assign dec[g] = (pos == 5'(g));
  end

  // Next selection
  always_comb begin
    nxt_q = q_ff;
    nxt_q.sel = dec;
  end

  // Selection register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '{sel: TAP_RESET};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign tap_sel = q_ff.sel;

  // ****************************************
  // Checks
  // ****************************************
  one_tap_a: assert property (@(posedge core_clk) disable iff (reset)
    $onehot(q_ff.sel) && q_ff.sel == (32'h0000_0001 << $past(pos)))
    else $error("tap selection not one-hot on count");

endmodule

`default_nettype wire

// [rtl/tpc_top.sv]
/*
  Control logic of a push-button digital potentiometer: debounced
  raise and lower buttons drive a saturating wiper count with slow
  and fast scan, decoded to one tap switch; the count is saved to
  and recalled from an outside nonvolatile store.
  Assumes button and store-enable pins plus power_fail are
  asynchronous, and the nonvolatile recall word is valid on the
  same clock as soon as reset is released.
*/
`timescale 1ns/1ns
`default_nettype none

module tpc_top
  import tpc_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int SLOW_CYC = SLOW_SCAN_CYC,
  parameter int FAST_CYC = FAST_SCAN_CYC,
  parameter int HOLD_CYC = FAST_AFTER_CYC,
  parameter int TW = TMR_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Button and store-enable pins
  input wire logic raise_button_n,
  input wire logic lower_button_n,
  input wire logic store_enable_n,
  output logic raise_pullup_en,
  output logic lower_pullup_en,
  // Supply monitor
  input wire logic power_fail,
  // Nonvolatile store
  input wire logic [4:0] nv_recall_data,
  output logic nv_store,
  output logic [4:0] nv_store_data,
  // Wiper
  output logic [4:0] wiper_pos,
  output logic [31:0] tap_sel,
  output logic scan_fast,
  output logic standby
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (DEB_CYC < 2 || SLOW_CYC < 2 || FAST_CYC < 2 || HOLD_CYC < 2) begin : g_chk_min
    $error("tpc_top: timing counts must be at least 2");
  end
  if (HOLD_CYC >= (2 ** TW) || SLOW_CYC >= (2 ** TW) || FAST_CYC >= (2 ** TW) ||
      DEB_CYC + SETTLE_EXTRA_CYC >= (2 ** TW)) begin : g_chk_w
    $error("tpc_top: timer width too small");
  end

  localparam int SETTLE_CYC = DEB_CYC + SETTLE_EXTRA_CYC;

  // ****************************************
  // Input filters
  // ****************************************
  logic raise_lvl_n;
  logic lower_lvl_n;
  logic store_lvl_n;

  // Buttons release at once so stepping stops promptly
  tpc_debounce #(
    .DEB_CYC(DEB_CYC),
    .CW(TW),
    .FILTER_RELEASE(1'b0)
  ) u_raise_deb (
    .core_clk(core_clk),
    .reset(reset),
    .pin_n(raise_button_n),
    .level_n(raise_lvl_n)
  );

  tpc_debounce #(
    .DEB_CYC(DEB_CYC),
    .CW(TW),
    .FILTER_RELEASE(1'b0)
  ) u_lower_deb (
    .core_clk(core_clk),
    .reset(reset),
    .pin_n(lower_button_n),
    .level_n(lower_lvl_n)
  );

  // Store enable filtered both ways, a push and a release
  tpc_debounce #(
    .DEB_CYC(DEB_CYC),
    .CW(TW),
    .FILTER_RELEASE(1'b1)
  ) u_store_deb (
    .core_clk(core_clk),
    .reset(reset),
    .pin_n(store_enable_n),
    .level_n(store_lvl_n)
  );

  // ****************************************
  // Control state
  // ****************************************
  typedef struct packed {
    tpc_state_type state;
    logic [4:0] pos;
    logic [TW-1:0] timer;
    logic [TW-1:0] hold;
    logic dir_up;
    logic boot_high;
    logic pf_s1;
    logic pf_s2;
    logic pf_prev;
    logic store_prev;
    logic nv_store;
    logic [4:0] nv_data;
  } tpc_ctl_type;

  tpc_ctl_type q_ff;
  tpc_ctl_type nxt_q;

  logic up_pr;
  logic dn_pr;
  logic lock;
  logic held;
  logic step;
  logic step_up;
  logic pf_rise;
  logic running;

  // Qualified press and lock terms
  always_comb begin
    up_pr = ~raise_lvl_n;
    dn_pr = ~lower_lvl_n;
    lock = q_ff.boot_high & ~store_lvl_n;
    held = (q_ff.dir_up ? up_pr : dn_pr) & ~lock & ~q_ff.pf_s2;
    pf_rise = q_ff.pf_s2 & ~q_ff.pf_prev;
    running = (q_ff.state == ST_IDLE) || (q_ff.state == ST_SLOW) ||
              (q_ff.state == ST_FAST);
  end

  // Sequencer, scan timing and saves
  always_comb begin
    nxt_q = q_ff;
    step = 1'b0;
    step_up = q_ff.dir_up;
    nxt_q.nv_store = 1'b0;
    nxt_q.pf_s1 = power_fail;
    nxt_q.pf_s2 = q_ff.pf_s1;
    nxt_q.pf_prev = q_ff.pf_s2;
    nxt_q.store_prev = store_lvl_n;
    case (q_ff.state)
      ST_RECALL: begin
        // First cycle after reset: restore saved position
        nxt_q.pos = nv_recall_data;
        nxt_q.timer = '0;
        nxt_q.state = ST_SETTLE;
      end
      ST_SETTLE: begin
        // Wait for the store-enable filter, then note its level
        nxt_q.timer = q_ff.timer + 1'b1;
        if (q_ff.timer == TW'(SETTLE_CYC - 1)) begin
          nxt_q.boot_high = store_lvl_n;
          nxt_q.timer = '0;
          nxt_q.state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // First step at the end of debounce
        if (!lock && !q_ff.pf_s2 && (up_pr || dn_pr)) begin
          step = 1'b1;
          step_up = up_pr;
          nxt_q.dir_up = up_pr;
          nxt_q.timer = '0;
          nxt_q.hold = '0;
          nxt_q.state = ST_SLOW;
        end
      end
      ST_SLOW: begin
        if (!held) begin
          nxt_q.state = ST_IDLE;
        end else begin
          nxt_q.timer = q_ff.timer + 1'b1;
          nxt_q.hold = q_ff.hold + 1'b1;
          if (q_ff.hold == TW'(HOLD_CYC - 1)) begin
            nxt_q.timer = '0;
            nxt_q.state = ST_FAST;
          end else if (q_ff.timer == TW'(SLOW_CYC - 1)) begin
            step = 1'b1;
            nxt_q.timer = '0;
          end
        end
      end
      ST_FAST: begin
        if (!held) begin
          nxt_q.state = ST_IDLE;
        end else begin
          nxt_q.timer = q_ff.timer + 1'b1;
          if (q_ff.timer == TW'(FAST_CYC - 1)) begin
            step = 1'b1;
            nxt_q.timer = '0;
          end
        end
      end
      default: begin
        nxt_q.state = ST_IDLE;
      end
    endcase
    // Saturating count, no wrap at either end
    if (step) begin
      if (step_up && q_ff.pos != POS_MAX) begin
        nxt_q.pos = q_ff.pos + 5'h01;
      end else if (!step_up && q_ff.pos != POS_MIN) begin
        nxt_q.pos = q_ff.pos - 5'h01;
      end
    end
    // Automatic save on supply loss, manual save on release
    if (running) begin
      if (pf_rise && !store_lvl_n) begin
        nxt_q.nv_store = 1'b1;
        nxt_q.nv_data = q_ff.pos;
      end else if (store_lvl_n && !q_ff.store_prev) begin
        nxt_q.nv_store = 1'b1;
        nxt_q.nv_data = q_ff.pos;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      q_ff <= '{state: ST_RECALL, pos: POS_RESET, timer: '0, hold: '0,
                dir_up: 1'b0, boot_high: 1'b0, pf_s1: 1'b0, pf_s2: 1'b0,
                pf_prev: 1'b0, store_prev: 1'b1, nv_store: 1'b0,
                nv_data: POS_RESET};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ****************************************
  // Tap decode and outputs
  // ****************************************
  tpc_tap_decode u_dec (
    .core_clk(core_clk),
    .reset(reset),
    .pos(q_ff.pos),
    .tap_sel(tap_sel)
  );

  // Pad pull-ups always on, so open buttons read high
  assign raise_pullup_en = 1'b1;
  assign lower_pullup_en = 1'b1;
  assign nv_store = q_ff.nv_store;
  assign nv_store_data = q_ff.nv_data;
  assign wiper_pos = q_ff.pos;
  assign scan_fast = (q_ff.state == ST_FAST);
  assign standby = (q_ff.state == ST_IDLE);

  // ****************************************
  // Checks
  // ****************************************
  localparam logic [TW-1:0] HOLD_LAST = TW'(HOLD_CYC - 1);

  unit_step_a: assert property (@(posedge core_clk) disable iff (reset)
    (q_ff.state != ST_RECALL) |=>
      ({1'b0, q_ff.pos} == {1'b0, $past(q_ff.pos)}) ||
      ({1'b0, q_ff.pos} == {1'b0, $past(q_ff.pos)} + 6'h01) ||
      ({1'b0, q_ff.pos} + 6'h01 == {1'b0, $past(q_ff.pos)}))
    else $error("wiper moved by more than one tap");

  top_sat_a: assert property (@(posedge core_clk) disable iff (reset)
    (step && step_up && q_ff.pos == POS_MAX) |=> q_ff.pos == POS_MAX)
    else $error("count wrapped past top tap");

  bottom_sat_a: assert property (@(posedge core_clk) disable iff (reset)
    (step && !step_up && q_ff.pos == POS_MIN) |=> q_ff.pos == POS_MIN)
    else $error("count wrapped past bottom tap");

  raise_step_a: assert property (@(posedge core_clk) disable iff (reset)
    (q_ff.state == ST_IDLE && up_pr && !lock && !q_ff.pf_s2 && q_ff.pos != POS_MAX)
      |=> q_ff.pos == $past(q_ff.pos) + 5'h01 && q_ff.state == ST_SLOW)
    else $error("raise press did not step up");

  lock_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (q_ff.state == ST_IDLE && lock) |=> q_ff.state == ST_IDLE && $stable(q_ff.pos))
    else $error("buttons acted while locked");

  release_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    ((q_ff.state == ST_SLOW || q_ff.state == ST_FAST) && !held)
      |=> q_ff.state == ST_IDLE && $stable(q_ff.pos))
    else $error("stepping continued after release");

  fast_entry_a: assert property (@(posedge core_clk) disable iff (reset)
    $rose(q_ff.state == ST_FAST) |-> $past(q_ff.hold) == HOLD_LAST)
    else $error("fast scan entered at wrong time");

  store_word_a: assert property (@(posedge core_clk) disable iff (reset)
    q_ff.nv_store |-> q_ff.nv_data == $past(q_ff.pos) && $past(running))
    else $error("saved word differs from count");

  recall_load_a: assert property (@(posedge core_clk) disable iff (reset)
    (q_ff.state == ST_RECALL) |=> q_ff.pos == $past(nv_recall_data))
    else $error("recall did not load counter");

endmodule

`default_nettype wire

// [dv/tpc_button_model.sv]
/*
  Push-button and logic-level model for the tap counter pins.
  Assumes the bench sets the hold requests just after a falling edge.
*/
`timescale 1ns/1ns
`default_nettype none

module tpc_button_model (
  // Press requests from the bench
  input wire logic hold_raise,
  input wire logic hold_lower,
  input wire logic hold_store,
  // Pins towards the block
  output logic raise_button_n,
  output logic lower_button_n,
  output logic store_enable_n
);
  // ****************************************
  // Switches to ground with pull-ups
  // ****************************************
  // An open switch floats to the pull-up level, a closed one pulls low
  assign raise_button_n = hold_raise ? 1'h0 : 1'h1;
  assign lower_button_n = hold_lower ? 1'h0 : 1'h1;
  // Store pin left high for manual save, held low for automatic save
  assign store_enable_n = hold_store ? 1'h0 : 1'h1;
endmodule

`default_nettype wire

// [dv/tpc_top_tb.sv]
/*
  Self-checking bench of the tap counter with short timing counts.
  Assumes the pin model stands between the bench and the button pins.
*/
`timescale 1ns/1ns
`default_nettype none

module tpc_top_tb;
  import tpc_pkg::*;
  localparam int DEB = 8;
  localparam int SLW = 20;
  localparam int FST = 6;
  localparam int HLD = 60;
  // Starts low so time zero brings no false falling edge
  logic core_clk = 1'h0;
  logic reset, hold_raise, hold_lower, hold_store, power_fail, prev_run;
  logic raise_button_n, lower_button_n, store_enable_n;
  logic raise_pullup_en, lower_pullup_en, nv_store, scan_fast, standby;
  logic [4:0] nv_recall_data, nv_store_data, wiper_pos, exp_pos, last_pos;
  logic [31:0] tap_sel, seed;
  logic [4:0] pos_q[$];
  logic [4:0] sto_q[$];
  int mismatches, num_checks, gap, wait_n;

  // ****************************************
  // Design and pin model
  // ****************************************
  tpc_top #(.DEB_CYC(DEB), .SLOW_CYC(SLW), .FAST_CYC(FST), .HOLD_CYC(HLD), .TW(12)) u_tpc_top (
    .core_clk(core_clk), .reset(reset), .raise_button_n(raise_button_n),
    .lower_button_n(lower_button_n), .store_enable_n(store_enable_n),
    .raise_pullup_en(raise_pullup_en), .lower_pullup_en(lower_pullup_en),
    .power_fail(power_fail), .nv_recall_data(nv_recall_data), .nv_store(nv_store),
    .nv_store_data(nv_store_data), .wiper_pos(wiper_pos), .tap_sel(tap_sel),
    .scan_fast(scan_fast), .standby(standby));
  tpc_button_model u_tpc_button_model (
    .hold_raise(hold_raise), .hold_lower(hold_lower), .hold_store(hold_store),
    .raise_button_n(raise_button_n), .lower_button_n(lower_button_n),
    .store_enable_n(store_enable_n));

  // ****************************************
  // Helpers
  // ****************************************
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic timeout();
    mismatches++;
    $display("[FAIL] %0t wait ran out", $time);
    test_done();
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Notes the next step and waits for it; at an end no step may come
  task automatic expect_step(input logic up);
    logic [4:0] nxt;
    if (up) nxt = (exp_pos == POS_MAX) ? exp_pos : exp_pos + 5'h01;
    else nxt = (exp_pos == POS_MIN) ? exp_pos : exp_pos - 5'h01;
    gap = 0;
    if (nxt === exp_pos) begin
      cyc(SLW + 4);
    end else begin
      pos_q.push_back(nxt);
      exp_pos = nxt;
      while (wiper_pos !== nxt) begin
        cyc(1);
        gap++;
        if (gap > DEB + SLW + 10) timeout();
      end
    end
  endtask

  // Reset with a saved word and a store pin level, then wait for idle
  task automatic do_reset(input logic [4:0] rec, input logic st);
    reset <= 1'h1;
    hold_store = st;
    nv_recall_data = rec;
    cyc(20);
    pos_q.push_back(rec);
    exp_pos = rec;
    reset <= 1'h0;
    wait_n = 0;
    while (standby !== 1'h1) begin
      cyc(1);
      wait_n++;
      if (wait_n > DEB + 20) timeout();
    end
  endtask

  // ****************************************
  // Clock
  // ****************************************
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // Output watcher
  // ****************************************
  // Takes the oldest note whenever the wiper moves or a save pulses
  always @(negedge core_clk) begin
    if (reset) begin
      prev_run = 1'h0;
    end else begin
      if (prev_run) check(tap_sel, 32'h1 << last_pos);
      if (wiper_pos !== last_pos) begin
        if (pos_q.size() == 0) check(32'(wiper_pos), 32'(last_pos));
        else check(32'(wiper_pos), 32'(pos_q.pop_front()));
      end
      if (nv_store === 1'h1) begin
        if (sto_q.size() == 0) check(32'h1, 32'h0);
        else check(32'(nv_store_data), 32'(sto_q.pop_front()));
      end
      prev_run = 1'h1;
    end
    last_pos = wiper_pos;
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset = 1'h1;
    hold_raise = 1'h0;
    hold_lower = 1'h0;
    hold_store = 1'h0;
    power_fail = 1'h0;
    nv_recall_data = 5'h00;
    exp_pos = 5'h00;
    mismatches = 0;
    num_checks = 0;
    seed = xs(32'h38);
    do_reset(5'h1C + {3'h0, seed[1:0]}, 1'h0);
    check(32'(raise_pullup_en & lower_pullup_en), 32'h1);
    // Glitch shorter than the debounce
    seed = xs(seed);
    hold_raise = 1'h1;
    cyc(1 + int'(seed[2:0]) % 5);
    hold_raise = 1'h0;
    cyc(30);
    // Short press gives one step
    hold_lower = 1'h1;
    expect_step(1'h0);
    hold_lower = 1'h0;
    cyc(SLW + 10);
    // Hold raise into the top end
    hold_raise = 1'h1;
    repeat (5) expect_step(1'h1);
    hold_raise = 1'h0;
    cyc(20);
    check(32'(wiper_pos), 32'(POS_MAX));
    // Manual mode: supply loss saves nothing, store low locks buttons
    power_fail = 1'h1;
    cyc(6);
    power_fail = 1'h0;
    hold_store = 1'h1;
    cyc(DEB + 6);
    hold_lower = 1'h1;
    cyc(40);
    hold_lower = 1'h0;
    cyc(10);
    sto_q.push_back(exp_pos);
    hold_store = 1'h0;
    cyc(DEB + 10);
    check(32'(sto_q.size()), 32'h0);
    // Store glitch shorter than the debounce saves nothing
    hold_store = 1'h1;
    cyc(3);
    hold_store = 1'h0;
    cyc(DEB + 10);
    // Long hold: slow scan, then fast scan, then release
    hold_lower = 1'h1;
    expect_step(1'h0);
    expect_step(1'h0);
    check(32'(gap), 32'(SLW));
    check(32'(scan_fast), 32'h0);
    wait_n = 0;
    while (scan_fast !== 1'h1) begin
      expect_step(1'h0);
      wait_n++;
      if (wait_n > 6) timeout();
    end
    expect_step(1'h0);
    expect_step(1'h0);
    check(32'(gap), 32'(FST));
    hold_lower = 1'h0;
    cyc(5);
    check(32'(standby), 32'h1);
    check(32'(scan_fast), 32'h0);
    cyc(SLW + 10);
    // Automatic mode: supply loss saves, buttons live, bottom end holds
    seed = xs(seed);
    do_reset(5'h01 + {4'h0, seed[0]}, 1'h1);
    sto_q.push_back(exp_pos);
    power_fail = 1'h1;
    cyc(6);
    power_fail = 1'h0;
    cyc(10);
    check(32'(sto_q.size()), 32'h0);
    hold_lower = 1'h1;
    repeat (4) expect_step(1'h0);
    hold_lower = 1'h0;
    cyc(10);
    check(32'(wiper_pos), 32'(POS_MIN));
    test_done();
  end
endmodule

`default_nettype wire
